// [core/slrf_rx.sv]
// Serial link receiver: bit recovery, deserialiser, decoder, byte framer and ready strobe.
`timescale 1ns/1ns
`include "slrf_cfg.svh"

module slrf_rx
   import slrf_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Serial line.
   input wire logic serialLineIn,
   // Host controls.
   input wire logic framerRequest,
   input wire logic selfTestEnableN,
   // Parallel output.
   output logic byteClockOut,
   output logic [7:0] parallelDataOut,
   output logic specialCharFlag,
   output logic receivedViolation,
   output logic readyN,
   // Register port.
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Interrupt.
   output logic irq
);

   localparam logic [2:0] PH_LAST = 3'(`SLRF_BIT_CYC - 1);
   localparam logic [2:0] PH_MID = 3'(`SLRF_BIT_CYC / 2);
   localparam logic [3:0] CNT_LAST = 4'(`SLRF_CHAR_BITS - 1);
   localparam logic [3:0] CNT_UPD = 4'(`SLRF_UPD_BIT);
   localparam logic [3:0] CNT_FALL = 4'(`SLRF_FALL_BIT);

   function automatic logic isK285(input logic [9:0] c);
      isK285 = (c == `SLRF_K285_NEG) || (c == `SLRF_K285_POS);
   endfunction : isK285

   slrf_state_t s_ff;
   slrf_state_t nxt_s;
   slrf_dec_t dec1;
   logic lineEdge;
   logic bitStb;
   logic [9:0] srNext;
   logic kMatch;
   logic capt;
   logic upd;
   logic fallEv;
   logic pulse;
   logic tagNew;
   logic evViol;
   logic evSync;

   // Decodes the character that is next to reach the outputs.
   slrf_dec slrf_dec_i (
      .code(s_ff.st1.code),
      .dec(dec1)
   );

   always_comb begin
      nxt_s = s_ff;
      lineEdge = 1'b0;
      bitStb = 1'b0;
      srNext = {s_ff.sr[8:0], serialLineIn};
      kMatch = isK285(srNext);
      capt = 1'b0;
      upd = 1'b0;
      fallEv = 1'b0;
      pulse = 1'b0;
      tagNew = 1'b0;
      evViol = 1'b0;
      evSync = 1'b0;

      // Phase counter restarts on every transition and free-runs at the nominal
      // bit time between them, so the sample point sits mid-bit.
      nxt_s.lineD = serialLineIn;
      lineEdge = serialLineIn != s_ff.lineD;
      if (lineEdge) begin
         nxt_s.ph = 3'h0;
      end else if (s_ff.ph == PH_LAST) begin
         nxt_s.ph = 3'h0;
      end else begin
         nxt_s.ph = s_ff.ph + 3'h1;
      end
      bitStb = s_ff.ph == PH_MID;

      if (bitStb) begin
         nxt_s.sr = srNext;
         capt = (s_ff.bitCnt == CNT_LAST) || (s_ff.frReq && kMatch);
         upd = !capt && (s_ff.bitCnt == CNT_UPD);
         fallEv = s_ff.byteClk && (capt || s_ff.bitCnt == CNT_FALL);
         if (capt) begin
            nxt_s.bitCnt = 4'h0;
         end else begin
            nxt_s.bitCnt = s_ff.bitCnt + 4'h1;
         end
      end

      // The byte clock falls late in the character; the framer request is taken
      // only there, and leaving or entering the search is decided at that point.
      if (fallEv) begin
         nxt_s.byteClk = 1'b0;
         nxt_s.frReq = framerRequest;
         if (!framerRequest) begin
            nxt_s.fr = FR_OFF;
         end else if (s_ff.fr == FR_OFF) begin
            nxt_s.fr = FR_SEARCH;
            nxt_s.readyN = 1'b1;
         end
      end

      if (capt) begin
         // Two-deep character pipeline gives the ready logic one character of look-ahead.
         tagNew = kMatch && s_ff.frReq && (s_ff.fr == FR_SEARCH);
         nxt_s.st1 = s_ff.st0;
         nxt_s.st0.code = srNext;
         nxt_s.st0.tag = tagNew;
         nxt_s.readyN = 1'b1;
         if (tagNew) begin
            nxt_s.fr = FR_FOUND;
         end
      end

      if (upd) begin
         nxt_s.byteClk = 1'b1;
         if (s_ff.encMode) begin
            nxt_s.data = dec1.data;
            nxt_s.sc = dec1.k;
            nxt_s.viol = dec1.err;
            evViol = dec1.err;
         end else begin
            {nxt_s.sc, nxt_s.data, nxt_s.viol} = s_ff.st1.code;
         end
         if (!s_ff.encMode) begin
            pulse = isK285(s_ff.st1.code);
         end else if (!selfTestEnableN) begin
            pulse = 1'b1;
         end else begin
            pulse = !(isK285(s_ff.st1.code) && isK285(s_ff.st0.code));
         end
         case (s_ff.fr)
            FR_SEARCH: begin
               nxt_s.readyN = 1'b1;
            end
            FR_FOUND: begin
               if (s_ff.st1.tag) begin
                  nxt_s.readyN = 1'b0;
                  nxt_s.fr = FR_SYNC;
                  evSync = 1'b1;
               end else begin
                  nxt_s.readyN = 1'b1;
               end
            end
            default: begin
               nxt_s.readyN = !pulse;
            end
         endcase
      end

      // Register writes; hardware events are merged after the clear so they win.
      if (regWr) begin
         case (regAddr)
            `SLRF_REG_CTRL: nxt_s.encMode = regWdata[`SLRF_CTRL_ENC];
            `SLRF_REG_STAT: nxt_s.stat = s_ff.stat & ~regWdata[1:0];
            `SLRF_REG_MASK: nxt_s.mask = regWdata[1:0];
            default: nxt_s.mask = s_ff.mask;
         endcase
      end
      if (evViol) begin
         nxt_s.stat[`SLRF_STAT_VIOL] = 1'b1;
      end
      if (evSync) begin
         nxt_s.stat[`SLRF_STAT_SYNC] = 1'b1;
      end
      nxt_s.irq = |(nxt_s.stat & nxt_s.mask);

      // Read data stands for exactly one cycle after the strobe.
      nxt_s.rdata = 8'h00;
      if (regRd) begin
         case (regAddr)
            `SLRF_REG_CTRL: nxt_s.rdata = {7'h00, s_ff.encMode};
            `SLRF_REG_STAT: nxt_s.rdata = {6'h00, s_ff.stat};
            `SLRF_REG_MASK: nxt_s.rdata = {6'h00, s_ff.mask};
            `SLRF_REG_LIVE: nxt_s.rdata = {4'h0, s_ff.fr == FR_SYNC,
                                            s_ff.fr == FR_SEARCH || s_ff.fr == FR_FOUND,
                                            s_ff.frReq, s_ff.byteClk};
            default: nxt_s.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_ff <= '0;
         s_ff.readyN <= 1'b1;
         s_ff.encMode <= `SLRF_CTRL_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // The output flops add the final fraction of latency beyond the bit pipeline.
   assign byteClockOut = s_ff.byteClk;
   assign parallelDataOut = s_ff.data;
   assign specialCharFlag = s_ff.sc;
   assign receivedViolation = s_ff.viol;
   assign readyN = s_ff.readyN;
   assign regRdata = s_ff.rdata;
   assign irq = s_ff.irq;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   a_bit_spacing:
      assert property (bitStb |=> !bitStb [*2])
      else $error("bit samples closer than three cycles");

   a_clk_rise:
      assert property ($rose(s_ff.byteClk) |-> $past(upd))
      else $error("byte clock rose without an output update");

   a_ready_fall:
      assert property ($fell(s_ff.readyN) |-> $past(upd) && $rose(s_ff.byteClk))
      else $error("ready fell away from the byte clock rise");

   a_ready_rise:
      assert property ($fell(s_ff.readyN) |-> (s_ff.readyN == 1'b0) [*8])
      else $error("ready low pulse too short");

   a_kfield_high:
      assert property ((upd && s_ff.encMode && selfTestEnableN &&
                        (s_ff.fr == FR_OFF || s_ff.fr == FR_SYNC) &&
                        isK285(s_ff.st1.code) && isK285(s_ff.st0.code)) |=> s_ff.readyN)
      else $error("ready pulsed inside a run of sync characters");

   a_bypass_ready:
      assert property ((upd && !s_ff.encMode && (s_ff.fr == FR_OFF || s_ff.fr == FR_SYNC))
                       |=> s_ff.readyN != isK285($past(s_ff.st1.code)))
      else $error("bypass ready does not mark the sync character");

   a_req_sample:
      assert property (!fallEv |=> s_ff.frReq == $past(s_ff.frReq))
      else $error("framer request taken outside the byte clock fall");

   a_realign:
      assert property ((bitStb && s_ff.frReq && kMatch)
                       |=> s_ff.bitCnt == 4'h0 && s_ff.st0.code == $past(srNext))
      else $error("sync character did not set the byte boundary");

   a_search_high:
      assert property ((s_ff.fr == FR_SEARCH && $past(s_ff.fr) == FR_SEARCH) |-> s_ff.readyN)
      else $error("ready low while the framer searches");

   a_align_low:
      assert property ((s_ff.fr == FR_FOUND && upd && s_ff.st1.tag)
                       |=> !s_ff.readyN && s_ff.fr == FR_SYNC)
      else $error("aligning sync character not signalled");

   a_raw_bits:
      assert property ((upd && !s_ff.encMode)
                       |=> {s_ff.sc, s_ff.data, s_ff.viol} == $past(s_ff.st1.code))
      else $error("bypass output differs from the received code");

   a_viol_flag:
      assert property ((upd && s_ff.encMode) |=> s_ff.viol == $past(dec1.err))
      else $error("violation flag not aligned with its byte");

   a_irq_level:
      assert property (s_ff.irq == |(s_ff.stat & s_ff.mask))
      else $error("interrupt does not follow status and mask");

   a_clk_fall:
      assert property ($fell(s_ff.byteClk) |-> $past(fallEv))
      else $error("byte clock fell away from its fall point");

   a_clk_high:
      assert property (($rose(s_ff.byteClk) && !s_ff.frReq) |-> s_ff.byteClk [*8])
      else $error("byte clock high phase too short");

   a_clk_low:
      assert property ($fell(s_ff.byteClk) |-> !s_ff.byteClk [*8])
      else $error("byte clock low phase too short");

   a_ready_high:
      assert property ($rose(s_ff.readyN) |-> s_ff.readyN [*8])
      else $error("ready high gap too short");

   a_search_enter:
      assert property ((fallEv && framerRequest && s_ff.fr == FR_OFF)
                       |=> s_ff.fr == FR_SEARCH && s_ff.readyN)
      else $error("framer request did not start the search");

   a_req_drop:
      assert property ((fallEv && !capt && !framerRequest) |=> s_ff.fr == FR_OFF)
      else $error("framer still active without the request");

   a_sync_byte:
      assert property ((upd && s_ff.encMode && isK285(s_ff.st1.code))
                       |=> s_ff.sc && s_ff.data == `SLRF_K285_DATA)
      else $error("sync character not decoded to its byte");

   a_pipe_step:
      assert property (capt |=> s_ff.st1 == $past(s_ff.st0))
      else $error("character pipeline skipped a stage");

   a_phase_zero:
      assert property (lineEdge |=> s_ff.ph == 3'h0)
      else $error("bit phase not restarted at a line transition");

   a_phase_wrap:
      assert property ((!lineEdge && s_ff.ph == PH_LAST) |=> s_ff.ph == 3'h0)
      else $error("bit phase did not free-run at the nominal bit time");

   a_viol_status:
      assert property (evViol |=> s_ff.stat[`SLRF_STAT_VIOL])
      else $error("violation not recorded in the status");

   a_sync_status:
      assert property (evSync |=> s_ff.stat[`SLRF_STAT_SYNC])
      else $error("framer sync not recorded in the status");

   a_enc_write:
      assert property ((regWr && regAddr == `SLRF_REG_CTRL)
                       |=> s_ff.encMode == $past(regWdata[`SLRF_CTRL_ENC]))
      else $error("mode write not taken");

endmodule : slrf_rx

// [core/slrf_cfg.svh]
// Constants of the serial link receiver and framer: timing, codes and register map.
`ifndef SLRF_CFG_SVH
`define SLRF_CFG_SVH

// System clock period and the nominal bit time the recovery loop free-runs at.
`define SLRF_CLK_NS 10
`define SLRF_BIT_NS 40
`define SLRF_BIT_CYC (`SLRF_BIT_NS / `SLRF_CLK_NS)

// Character framing: bits per character, output update bit and byte clock fall bit.
`define SLRF_CHAR_BITS 10
`define SLRF_UPD_BIT 3
`define SLRF_FALL_BIT 8

// Extra output delay beyond the bit pipeline, realised by the output flops.
`define SLRF_LAT_NS 10
`define SLRF_LAT_CYC ((`SLRF_LAT_NS + `SLRF_CLK_NS - 1) / `SLRF_CLK_NS)

// Sync character in both disparities, bit a first.
`define SLRF_K285_NEG 10'h0FA
`define SLRF_K285_POS 10'h305
// Decoded byte of the sync character.
`define SLRF_K285_DATA 8'hBC

// Register offsets.
`define SLRF_REG_CTRL 2'h0
`define SLRF_REG_STAT 2'h1
`define SLRF_REG_MASK 2'h2
`define SLRF_REG_LIVE 2'h3

// Field positions and reset values.
`define SLRF_CTRL_ENC 0
`define SLRF_STAT_VIOL 0
`define SLRF_STAT_SYNC 1
`define SLRF_CTRL_RST 1'h1

`endif

// [core/slrf_pkg.sv]
// Types shared by the serial link receiver and framer.
package slrf_pkg;

   typedef enum logic [1:0] {FR_OFF, FR_SEARCH, FR_FOUND, FR_SYNC} slrf_frame_t;

   typedef struct packed {
      logic [9:0] code;
      logic tag;
   } slrf_char_t;

   typedef struct packed {
      logic [7:0] data;
      logic k;
      logic err;
   } slrf_dec_t;

   typedef struct packed {
      logic lineD;
      logic [2:0] ph;
      logic [3:0] bitCnt;
      logic [9:0] sr;
      slrf_char_t st0;
      slrf_char_t st1;
      slrf_frame_t fr;
      logic frReq;
      logic byteClk;
      logic readyN;
      logic [7:0] data;
      logic sc;
      logic viol;
      logic encMode;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [7:0] rdata;
      logic irq;
   } slrf_state_t;

endpackage : slrf_pkg

// [core/slrf_dec.sv]
// Ten-bit transmission code to byte decoder with validity check.
`timescale 1ns/1ns
module slrf_dec
   import slrf_pkg::*;
(
   // Code word, bit a in the top position.
   input wire logic [9:0] code,
   // Decoded character.
   output slrf_dec_t dec
);

   function automatic logic [5:0] dec6(input logic [5:0] c);
      case (c)
         6'h27, 6'h18: dec6 = 6'h20;
         6'h1D, 6'h22: dec6 = 6'h21;
         6'h2D, 6'h12: dec6 = 6'h22;
         6'h31: dec6 = 6'h23;
         6'h35, 6'h0A: dec6 = 6'h24;
         6'h29: dec6 = 6'h25;
         6'h19: dec6 = 6'h26;
         6'h38, 6'h07: dec6 = 6'h27;
         6'h39, 6'h06: dec6 = 6'h28;
         6'h25: dec6 = 6'h29;
         6'h15: dec6 = 6'h2A;
         6'h34: dec6 = 6'h2B;
         6'h0D: dec6 = 6'h2C;
         6'h2C: dec6 = 6'h2D;
         6'h1C: dec6 = 6'h2E;
         6'h17, 6'h28: dec6 = 6'h2F;
         6'h1B, 6'h24: dec6 = 6'h30;
         6'h23: dec6 = 6'h31;
         6'h13: dec6 = 6'h32;
         6'h32: dec6 = 6'h33;
         6'h0B: dec6 = 6'h34;
         6'h2A: dec6 = 6'h35;
         6'h1A: dec6 = 6'h36;
         6'h3A, 6'h05: dec6 = 6'h37;
         6'h33, 6'h0C: dec6 = 6'h38;
         6'h26: dec6 = 6'h39;
         6'h16: dec6 = 6'h3A;
         6'h36, 6'h09: dec6 = 6'h3B;
         6'h0E, 6'h0F, 6'h30: dec6 = 6'h3C;
         6'h2E, 6'h11: dec6 = 6'h3D;
         6'h1E, 6'h21: dec6 = 6'h3E;
         6'h2B, 6'h14: dec6 = 6'h3F;
         default: dec6 = 6'h00;
      endcase
   endfunction : dec6

   function automatic logic [3:0] dec4(input logic [3:0] c);
      case (c)
         4'hB, 4'h4: dec4 = 4'h8;
         4'h9: dec4 = 4'h9;
         4'h5: dec4 = 4'hA;
         4'hC, 4'h3: dec4 = 4'hB;
         4'hD, 4'h2: dec4 = 4'hC;
         4'hA: dec4 = 4'hD;
         4'h6: dec4 = 4'hE;
         4'hE, 4'h1, 4'h7, 4'h8: dec4 = 4'hF;
         default: dec4 = 4'h0;
      endcase
   endfunction : dec4

   logic [5:0] r6;
   logic [3:0] r4;
   logic [3:0] fghj;
   logic alt7;

   always_comb begin
      // The positive-disparity sync group carries its 3b part complemented.
      fghj = (code[9:4] == 6'h30) ? ~code[3:0] : code[3:0];
      r6 = dec6(code[9:4]);
      r4 = dec4(fghj);
      alt7 = (code[3:0] == 4'h8) || (code[3:0] == 4'h7);
      dec.data = {r4[2:0], r6[4:0]};
      dec.k = (code[9:4] == 6'h0F) || (code[9:4] == 6'h30) ||
              (alt7 && (code[9:4] == 6'h3A || code[9:4] == 6'h05 ||
                        code[9:4] == 6'h36 || code[9:4] == 6'h09 ||
                        code[9:4] == 6'h2E || code[9:4] == 6'h11 ||
                        code[9:4] == 6'h1E || code[9:4] == 6'h21));
      dec.err = !r6[5] || !r4[3];
   end

endmodule : slrf_dec

// [dv/slrf_host_model.sv]
// Host side model: drives the framer request and logs each byte offered by the receiver.
`timescale 1ns/1ns
module slrf_host_model
   import slrf_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Bench control.
   input wire logic wantFrame,
   output logic framerRequest,
   // Receiver outputs.
   input wire logic byteClockOut,
   input wire logic [7:0] parallelDataOut,
   input wire logic specialCharFlag,
   input wire logic receivedViolation,
   input wire logic readyN,
   // Observations.
   output int rdyCount,
   output int kRdyCount,
   output int violCount,
   output int lowLen,
   output int period,
   output logic [7:0] lastData,
   output logic lastSc,
   output logic lastViol
);
   logic clkD;
   logic rdyD;
   int lowCnt;
   int perCnt;

   // Bytes are taken at the byte clock rise, as a clocked FIFO would.
   always_ff @(posedge mclk) begin
      clkD <= byteClockOut;
      rdyD <= readyN;
      framerRequest <= wantFrame;
      perCnt <= perCnt + 1;
      lowCnt <= readyN ? 0 : lowCnt + 1;
      if (readyN && !rdyD) begin
         lowLen <= lowCnt;
      end
      if (byteClockOut && !clkD) begin
         period <= perCnt;
         perCnt <= 1;
         if (receivedViolation) begin
            violCount <= violCount + 1;
         end
         if (!readyN) begin
            rdyCount <= rdyCount + 1;
            lastData <= parallelDataOut;
            lastSc <= specialCharFlag;
            lastViol <= receivedViolation;
            if (specialCharFlag && parallelDataOut == 8'hBC) begin
               kRdyCount <= kRdyCount + 1;
            end
         end
      end
      if (srst) begin
         framerRequest <= 1'h0;
         rdyCount <= 0;
         kRdyCount <= 0;
         violCount <= 0;
         perCnt <= 0;
      end
   end
endmodule : slrf_host_model

// [dv/slrf_rx_tb.sv]
// Self-checking testbench of the serial link receiver and framer.
`timescale 1ns/1ns
`include "slrf_cfg.svh"
module slrf_rx_tb;
   import slrf_pkg::*;
   logic mclk = 1'h0;
   logic srst = 1'h1;
   logic serialLineIn = 1'h0;
   logic wantFrame = 1'h0;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'h0;
   logic regRd = 1'h0;
   logic selfTestEnableN = 1'h1;
   logic framerRequest, byteClockOut, specialCharFlag, receivedViolation, readyN, irq;
   logic [7:0] parallelDataOut, regRdata, rd, lastData;
   logic lastSc, lastViol;
   int rdyCount, kRdyCount, violCount, lowLen, period, n_errors, cmp_count, r0, k0;
   logic bitQ[$];

   always #5 mclk = ~mclk;

   slrf_rx slrf_rx_i (.mclk(mclk), .srst(srst), .serialLineIn(serialLineIn),
      .framerRequest(framerRequest), .selfTestEnableN(selfTestEnableN),
      .byteClockOut(byteClockOut),
      .parallelDataOut(parallelDataOut), .specialCharFlag(specialCharFlag),
      .receivedViolation(receivedViolation), .readyN(readyN), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));

   slrf_host_model slrf_host_model_i (.mclk(mclk), .srst(srst), .wantFrame(wantFrame),
      .framerRequest(framerRequest), .byteClockOut(byteClockOut),
      .parallelDataOut(parallelDataOut), .specialCharFlag(specialCharFlag),
      .receivedViolation(receivedViolation), .readyN(readyN), .rdyCount(rdyCount),
      .kRdyCount(kRdyCount), .violCount(violCount), .lowLen(lowLen), .period(period),
      .lastData(lastData), .lastSc(lastSc), .lastViol(lastViol));

   // Far transmitter: four clocks per bit, filling with a neutral data character when idle.
   always begin
      repeat (4) @(posedge mclk);
      if (bitQ.size() == 0) begin
         for (int i = 9; i >= 0; i--) bitQ.push_back(1'(10'h2AA >> i));
      end
      serialLineIn <= bitQ.pop_front();
   end

   task automatic sendCode(input logic [9:0] c);
      for (int i = 9; i >= 0; i--) bitQ.push_back(c[i]);
   endtask : sendCode

   task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'h1;
      @(posedge mclk);
      regWr <= 1'h0;
   endtask : regWrite

   task automatic regRead(input logic [1:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge mclk);
      regRd <= 1'h0;
      #1 d = regRdata;
   endtask : regRead

   task automatic fail(input string m);
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, m);
   endtask : fail

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) fail($sformatf("byte %h expected %h", g, e));
   endtask : chk8

   task automatic chk1(input logic g, input logic e);
      cmp_count++;
      if (g !== e) fail($sformatf("bit %b expected %b", g, e));
   endtask : chk1

   task automatic chkInt(input int g, input int e);
      cmp_count++;
      if (g != e) fail($sformatf("count %0d expected %0d", g, e));
   endtask : chkInt

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   task automatic test_reset;
      chk1(readyN, 1'h1);
      chk1(irq, 1'h0);
      regRead(`SLRF_REG_CTRL, rd);
      chk8(rd, 8'h01);
      regRead(`SLRF_REG_MASK, rd);
      chk8(rd, 8'h00);
      regWrite(`SLRF_REG_LIVE, 8'hFF);
      regRead(`SLRF_REG_LIVE, rd);
      chk8(rd & 8'hF0, 8'h00);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_frame;
      wantFrame <= 1'h1;
      repeat (160) @(posedge mclk);
      r0 = rdyCount;
      k0 = kRdyCount;
      repeat (160) @(posedge mclk);
      chkInt(rdyCount, r0);
      // Three stray bits shift the stream off any earlier boundary.
      bitQ.push_back(1'h1);
      bitQ.push_back(1'h0);
      bitQ.push_back(1'h1);
      sendCode(`SLRF_K285_NEG);
      repeat (240) @(posedge mclk);
      chkInt(kRdyCount, k0 + 1);
      r0 = rdyCount;
      repeat (80) @(posedge mclk);
      chkInt(rdyCount, r0 + 2);
      chk8(lastData, 8'hB5);
      chk1(lastSc, 1'h0);
      regRead(`SLRF_REG_STAT, rd);
      chk1(rd[`SLRF_STAT_SYNC], 1'h1);
      wantFrame <= 1'h0;
      repeat (80) @(posedge mclk);
      $display("test_frame done");
   endtask : test_frame

   task automatic test_run;
      k0 = kRdyCount;
      sendCode(`SLRF_K285_POS);
      sendCode(`SLRF_K285_NEG);
      sendCode(`SLRF_K285_POS);
      repeat (280) @(posedge mclk);
      chkInt(kRdyCount, k0 + 1);
      chkInt(lowLen, 6 * `SLRF_BIT_CYC);
      chkInt(period, 10 * `SLRF_BIT_CYC);
      // With self-test low every character pulses ready, sync runs included.
      selfTestEnableN <= 1'h0;
      k0 = kRdyCount;
      sendCode(`SLRF_K285_POS);
      sendCode(`SLRF_K285_NEG);
      sendCode(`SLRF_K285_POS);
      repeat (280) @(posedge mclk);
      chkInt(kRdyCount, k0 + 3);
      selfTestEnableN <= 1'h1;
      $display("test_run done");
   endtask : test_run

   task automatic test_viol;
      regWrite(`SLRF_REG_STAT, 8'h03);
      regWrite(`SLRF_REG_MASK, 8'h00);
      r0 = violCount;
      sendCode(10'h3E0);
      repeat (200) @(posedge mclk);
      chk1(violCount > r0, 1'h1);
      chk1(irq, 1'h0);
      regRead(`SLRF_REG_STAT, rd);
      chk1(rd[`SLRF_STAT_VIOL], 1'h1);
      regWrite(`SLRF_REG_MASK, 8'h01);
      repeat (3) @(posedge mclk);
      chk1(irq, 1'h1);
      regWrite(`SLRF_REG_STAT, 8'h01);
      repeat (3) @(posedge mclk);
      chk1(irq, 1'h0);
      regRead(`SLRF_REG_STAT, rd);
      chk1(rd[`SLRF_STAT_VIOL], 1'h0);
      $display("test_viol done");
   endtask : test_viol

   task automatic test_bypass;
      regWrite(`SLRF_REG_CTRL, 8'h00);
      repeat (120) @(posedge mclk);
      r0 = rdyCount;
      sendCode(`SLRF_K285_POS);
      repeat (240) @(posedge mclk);
      chkInt(rdyCount, r0 + 1);
      chk1(lastSc, 1'h1);
      chk1(lastViol, 1'h1);
      chk8(lastData, 8'h82);
      regWrite(`SLRF_REG_CTRL, 8'h01);
      $display("test_bypass done");
   endtask : test_bypass

   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'h0;
      test_reset();
      test_frame();
      test_run();
      test_viol();
      test_bypass();
      stop_test();
   end

   // The tests need about two thousand clocks; ten times that means a hang.
   initial begin
      repeat (20000) @(posedge mclk);
      fail("watchdog expired");
      stop_test();
   end
endmodule : slrf_rx_tb
